// *** mcg_map.svh ***
// Constants of the master clock generation block.
// Assumes inclusion by the package and the top module only.
`ifndef MCG_MAP_SVH
`define MCG_MAP_SVH

`define MCG_CLK_PERIOD_NS 40
`define MCG_SRC_PLL 2'h3
`define MCG_IDIV_MAX 2'h3
`define MCG_ODIV_MAX 4'he
`define MCG_BAND_RSVD 2'h3
`define MCG_INC_BAND0 16'h0800
`define MCG_INC_BAND1 16'h0c00
`define MCG_INC_BAND2 16'h1000
`define MCG_INC_MAX 16'h7fff
`define MCG_INC_MIN 16'h0001

`endif

// *** mcg_osc_model.sv ***
// Oscillator source model feeding the clock block's oscillator pin.
// Assumes the bench clock; the level changes 1 ns after its rising edges.
`timescale 1ns/10ps
`default_nettype none

module mcg_osc_model (
	input wire logic clk,
	input wire logic [7:0] half,
	output logic osc
);
	logic [7:0] cnt;

	initial
	begin
		osc = 1'b0;
		cnt = 8'h0;
	end

	// Free running: toggles every half clk cycles
	always @(posedge clk)
	begin
		#1;
		cnt = cnt + 8'h1;
		if (cnt >= half)
		begin
			cnt = 8'h0;
			osc = ~osc;
		end
	end
endmodule : mcg_osc_model

`default_nettype wire

// *** mcg_pkg.sv ***
// Types of the master clock generation block.
// Assumes mcg_map.svh is on the include path.
`default_nettype none

package mcg_pkg;
	`include "mcg_map.svh"

	typedef struct packed {
		logic [1:0] clock_source_select;
		logic [1:0] input_div_field;
		logic [3:0] output_div_field;
		logic [4:0] feedback_mul_field;
		logic [1:0] vco_band_select;
	} mcg_pll_cfg_t;

	typedef enum logic [1:0] {
		MCG_FL_IDLE = 2'h0,
		MCG_FL_WAIT = 2'h1
	} mcg_fl_state_t;
endpackage : mcg_pkg

`default_nettype wire

// *** mcg_top.sv ***
// Master clock, CPU clock and flash wait control.
// Assumes the oscillator pin is sampled synchronously to clk; generated
// clocks are registered levels that change on clk edges.
// Contract
// R1: master clock source follows PLL configuration
// R2: CPU clock is master or master halved
// R3: peripheral clock equals CPU clock
// R4: bypass divides by input times output divider
// R5: bypass with dividers zero tracks oscillator
// R6: dividers limited to 3 and 14
// R7: source 11 enables PLL with multiplier
// R8: PLL frequency adjusts gradually, never jumps
// R9: VCO divided by output divider plus one
// R10: VCO band selects range, 11 reserved
// R11: core and external bus use CPU clock
// R12: flash access takes one plus wait cycles
// R13: wait count delays only non-sequential accesses
// R14: software sets wait count by CPU frequency
// R15: software covers 50 ns flash access time
// R16: source and halving switch without glitches
`timescale 1ns/10ps
`default_nettype none

module mcg_top
	import mcg_pkg::*;
#(
	parameter int INC_W = 16
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic osc_input_pin,
	input wire mcg_pll_cfg_t pll_config_reg,
	input wire logic cpu_clock_halve,
	input wire logic [1:0] flash_wait_count,
	input wire logic flash_req,
	input wire logic flash_seq,
	output logic master_clk,
	output logic cpu_clk,
	output logic sys_clk,
	output logic ebu_clk,
	output logic pll_enable,
	output logic pll_locked,
	output logic band_fault,
	output logic flash_busy,
	output logic flash_done
);
	`include "mcg_map.svh"

	logic osc_q;
	logic act_pll;
	logic act_halve;
	logic [3:0] odiv_eff;
	logic [7:0] nbyp;
	logic [7:0] byp_cnt;
	logic byp_edge;
	logic [1:0] ref_cnt;
	logic ref_tick;
	logic [INC_W-1:0] inc;
	logic [INC_W-1:0] acc;
	logic [INC_W:0] acc_sum;
	logic vco_edge;
	logic [6:0] vco_cnt;
	logic [6:0] vco_target;
	logic [3:0] pk_cnt;
	logic pll_edge;
	logic mc_edge;
	logic next_master;
	logic next_cpu;
	logic cpu_rise;
	mcg_fl_state_t fl_state;
	logic [1:0] fl_cnt;
	logic want_pll;

	assign want_pll = pll_config_reg.clock_source_select == `MCG_SRC_PLL;
	// Out-of-range output divider is held at its maximum
	assign odiv_eff = (pll_config_reg.output_div_field > `MCG_ODIV_MAX) ?
		`MCG_ODIV_MAX : pll_config_reg.output_div_field; // R6
	assign nbyp = (8'(pll_config_reg.input_div_field) + 8'h01) *
		(8'(odiv_eff) + 8'h01); // R4 R6

	// Bypass: one master edge per nbyp oscillator edges
	assign byp_edge = (osc_q != osc_input_pin) &&
		(byp_cnt + 8'h01 >= nbyp); // R4 R5
	always_ff @(posedge clk)
	begin
		osc_q <= srst ? 1'b0 : osc_input_pin;
		if (srst || act_pll)
			byp_cnt <= 8'h00;
		else if (osc_q != osc_input_pin)
			byp_cnt <= byp_edge ? 8'h00 : byp_cnt + 8'h01;
	end

	// PLL reference: oscillator rising edges through the input divider
	assign ref_tick = osc_input_pin && !osc_q &&
		(ref_cnt == pll_config_reg.input_div_field);
	assign acc_sum = {1'b0, acc} + {1'b0, inc};
	assign vco_edge = acc_sum[INC_W];
	assign vco_target = {pll_config_reg.feedback_mul_field, 1'b0} +
		7'h02; // R7
	always_ff @(posedge clk)
	begin
		if (srst || !act_pll)
		begin
			ref_cnt <= 2'h0;
			acc <= '0;
			vco_cnt <= 7'h00;
			pll_locked <= 1'b0;
			case (pll_config_reg.vco_band_select) // R10
				2'h0: inc <= INC_W'(`MCG_INC_BAND0);
				2'h1: inc <= INC_W'(`MCG_INC_BAND1);
				default: inc <= INC_W'(`MCG_INC_BAND2);
			endcase
		end
		else
		begin
			acc <= acc_sum[INC_W-1:0];
			if (osc_input_pin && !osc_q)
				ref_cnt <= ref_tick ? 2'h0 : ref_cnt + 2'h1;
			if (ref_tick)
			begin
				vco_cnt <= {6'h00, vco_edge};
				pll_locked <= vco_cnt == vco_target;
				// One step per reference period keeps the frequency smooth
				if (vco_cnt < vco_target && inc < INC_W'(`MCG_INC_MAX))
					inc <= inc + INC_W'(1); // R8
				else if (vco_cnt > vco_target && inc > INC_W'(`MCG_INC_MIN))
					inc <= inc - INC_W'(1); // R8
			end
			else if (vco_edge && vco_cnt != 7'h7f)
				vco_cnt <= vco_cnt + 7'h01;
		end
	end

	// Output prescaler on VCO edges
	assign pll_edge = vco_edge && (pk_cnt == odiv_eff); // R9
	always_ff @(posedge clk)
	begin
		if (srst || !act_pll)
			pk_cnt <= 4'h0;
		else if (vco_edge)
			pk_cnt <= pll_edge ? 4'h0 : pk_cnt + 4'h1; // R9
	end

	assign mc_edge = act_pll ? pll_edge : byp_edge; // R1
	assign next_master = master_clk ^ mc_edge;
	assign next_cpu = act_halve ? (cpu_clk ^ (mc_edge & ~master_clk)) :
		next_master; // R2
	assign cpu_rise = next_cpu && !cpu_clk;

	// Source and halving take effect only while both clocks rest low
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			act_pll <= 1'b0;
			act_halve <= 1'b0;
		end
		else if (!master_clk && !cpu_clk && !mc_edge)
		begin
			act_pll <= want_pll; // R16 R1
			act_halve <= cpu_clock_halve; // R16
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			master_clk <= 1'b0;
			cpu_clk <= 1'b0;
			sys_clk <= 1'b0;
			ebu_clk <= 1'b0;
			pll_enable <= 1'b0;
			band_fault <= 1'b0;
		end
		else
		begin
			master_clk <= next_master; // R1
			cpu_clk <= next_cpu; // R2
			sys_clk <= next_cpu; // R3
			ebu_clk <= next_cpu; // R11
			pll_enable <= act_pll; // R7
			band_fault <= pll_config_reg.vco_band_select ==
				`MCG_BAND_RSVD; // R10
		end
	end

	// Flash access timed in CPU clock rising edges
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			fl_state <= MCG_FL_IDLE;
			fl_cnt <= 2'h0;
			flash_done <= 1'b0;
			flash_busy <= 1'b0;
		end
		else
		begin
			flash_done <= 1'b0;
			case (fl_state)
				MCG_FL_IDLE:
					if (flash_req)
					begin
						fl_state <= MCG_FL_WAIT;
						flash_busy <= 1'b1;
						fl_cnt <= flash_seq ? 2'h0 : flash_wait_count; // R13
					end
				MCG_FL_WAIT:
					if (cpu_rise)
					begin
						if (fl_cnt == 2'h0)
						begin
							fl_state <= MCG_FL_IDLE;
							flash_busy <= 1'b0;
							flash_done <= 1'b1; // R12
						end
						else
							fl_cnt <= fl_cnt - 2'h1; // R12
					end
				default:
					fl_state <= MCG_FL_IDLE;
			endcase
		end
	end

	// Checking helpers
	logic [2:0] rise_cnt;
	logic [2:0] exp_len;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rise_cnt <= 3'h0;
			exp_len <= 3'h1;
		end
		else if (fl_state == MCG_FL_IDLE && flash_req)
		begin
			rise_cnt <= 3'h0;
			exp_len <= flash_seq ? 3'h1 : {1'b0, flash_wait_count} + 3'h1;
		end
		else if (fl_state == MCG_FL_WAIT && cpu_rise)
			rise_cnt <= rise_cnt + 3'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	mc_edge_flip_a: assert property ( // R1
		mc_edge |=> master_clk != $past(master_clk))
		else $error("master clock missed an edge");
	cpu_halve_a: assert property ( // R2
		act_halve && mc_edge && master_clk |=> cpu_clk == $past(cpu_clk))
		else $error("halved cpu clock toggled on falling edge");
	cpu_full_a: assert property ( // R2
		!act_halve && !$past(act_halve) && !$past(srst) |-> cpu_clk == master_clk)
		else $error("cpu clock differs from master clock");
	sys_ebu_a: assert property ( // R3 R11
		sys_clk == cpu_clk && ebu_clk == cpu_clk)
		else $error("derived clocks differ from cpu clock");
	byp_direct_a: assert property ( // R4 R5
		!act_pll && nbyp == 8'h01 && osc_q != osc_input_pin |-> mc_edge)
		else $error("undivided bypass missed an oscillator edge");
	odiv_clamp_a: assert property ( // R6
		odiv_eff <= `MCG_ODIV_MAX && byp_cnt < 8'h3c)
		else $error("divider exceeds its limit");
	pll_enable_a: assert property ( // R7
		act_pll |=> pll_enable)
		else $error("pll enable not raised");
	pll_step_a: assert property ( // R8
		act_pll && ref_tick |=> inc - $past(inc) <= INC_W'(1) ||
			$past(inc) - inc <= INC_W'(1))
		else $error("pll frequency jumped");
	pll_div_a: assert property ( // R9
		act_pll && mc_edge |-> vco_edge && pk_cnt == odiv_eff)
		else $error("master edge without vco divider wrap");
	band_rsvd_a: assert property ( // R10
		pll_config_reg.vco_band_select == `MCG_BAND_RSVD |=> band_fault)
		else $error("reserved band not flagged");
	flash_len_a: assert property ( // R12 R13
		flash_done |-> rise_cnt == exp_len)
		else $error("flash access length wrong");
	switch_low_a: assert property ( // R16
		$changed(act_pll) || $changed(act_halve) |->
			!$past(master_clk) && !$past(cpu_clk))
		else $error("clock switched while high");

	byp_div_c: cover property (!act_pll && nbyp > 8'h01 && mc_edge);
	pll_lock_c: cover property (act_pll && pll_locked);
	halve_sw_c: cover property ($rose(act_halve));
	flash_ws_c: cover property (flash_done && exp_len > 3'h1);
endmodule : mcg_top

`default_nettype wire

// *** tb_mcg_top.sv ***
// Self-checking bench of the master clock generation block.
// Assumes mcg_pkg and mcg_osc_model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_mcg_top;
	import mcg_pkg::*;
	logic clk = 1'b0, srst = 1'b1, osc, halve = 1'b0, req = 1'b0;
	logic seq = 1'b0, mclk, cclk, sclk, eclk, pen, plk, bf, busy, done;
	logic [1:0] ws = 2'h0;
	logic [7:0] half = 8'h03;
	mcg_pll_cfg_t cfg = 15'h0;
	int failures = 0, total_checks = 0, cyc = 0;

	mcg_top i_dut (.clk(clk), .srst(srst), .osc_input_pin(osc),
		.pll_config_reg(cfg), .cpu_clock_halve(halve),
		.flash_wait_count(ws), .flash_req(req), .flash_seq(seq),
		.master_clk(mclk), .cpu_clk(cclk), .sys_clk(sclk), .ebu_clk(eclk),
		.pll_enable(pen), .pll_locked(plk), .band_fault(bf),
		.flash_busy(busy), .flash_done(done));
	mcg_osc_model i_osc (.clk(clk), .half(half), .osc(osc));

	always #20 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic set(input logic [1:0] s, i, input logic [3:0] o,
		input logic h, input int n);
		@(posedge clk);
		#1;
		cfg = {s, i, o, 5'h3, 2'h0};
		halve = h;
		repeat (n) @(posedge clk);
	endtask : set

	task automatic ratio(input logic [1:0] i, input logic [3:0] o,
		input logic h, input int n, em, ec);
		int m, c;
		logic pm, pc;
		set(2'h0, i, o, h, 400);
		#2;
		m = 0;
		c = 0;
		pm = mclk;
		pc = cclk;
		repeat (n)
		begin
			@(posedge clk);
			#2;
			m += int'(mclk && !pm);
			c += int'(cclk && !pc);
			pm = mclk;
			pc = cclk;
		end
		check(m >= em - 1 && m <= em + 1, 1);
		check(c >= ec - 1 && c <= ec + 1, 1);
		$display("ratio test done");
	endtask : ratio

	task automatic t_follow();
		logic p;
		set(2'h1, 2'h0, 4'h0, 1'b0, 20);
		#2;
		p = osc;
		repeat (40)
		begin
			@(posedge clk);
			#2;
			check(mclk, p);
			check({cclk, sclk, eclk}, {3{mclk}});
			p = osc;
		end
		$display("follow test done");
	endtask : t_follow

	task automatic t_pll();
		set(2'h3, 2'h0, 4'h1, 1'b0, 300);
		#2;
		check(pen, 1'b1);
		@(posedge clk);
		#1;
		cfg.vco_band_select = 2'h3;
		repeat (3) @(posedge clk);
		#2;
		check(bf, 1'b1);
		@(posedge clk);
		#1;
		cfg.vco_band_select = 2'h1;
		repeat (3) @(posedge clk);
		#2;
		check(bf, 1'b0);
		set(2'h2, 2'h0, 4'h0, 1'b0, 3000);
		#2;
		check(pen, 1'b0);
		check(plk, 1'b0);
		// Reference of 32 clk and band start step of 16 clk: two per period
		@(posedge clk);
		#1;
		half = 8'h04;
		cfg = {2'h3, 2'h3, 4'h0, 5'h00, 2'h2};
		repeat (600) @(posedge clk);
		#2;
		check(pen, 1'b1);
		check(plk, 1'b1);
		$display("pll test done");
	endtask : t_pll

	task automatic t_flash(input logic [1:0] w, input logic s, input int e);
		int n;
		logic pc;
		@(posedge clk);
		#1;
		ws = w;
		seq = s;
		req = 1'b1;
		@(posedge clk);
		#1;
		req = 1'b0;
		check(busy, 1'b1);
		n = 0;
		pc = cclk;
		repeat (100)
		begin
			@(posedge clk);
			#2;
			n += int'(cclk && !pc);
			pc = cclk;
			if (done)
				break;
		end
		check(done, 1'b1);
		check(busy, 1'b0);
		check(n, e);
		$display("flash test done");
	endtask : t_flash

	task automatic end_of_test();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	initial
	begin
		repeat (6) @(posedge clk);
		#1;
		srst = 1'b0;
		t_follow();
		ratio(2'h0, 4'h0, 1'b0, 240, 40, 40);
		ratio(2'h1, 4'h1, 1'b0, 240, 10, 10);
		ratio(2'h1, 4'h1, 1'b1, 240, 10, 5);
		ratio(2'h3, 4'he, 1'b0, 1440, 4, 4);
		ratio(2'h3, 4'hf, 1'b0, 1440, 4, 4);
		// A 240 ns cpu period lets every wait count cover the array
		set(2'h0, 2'h0, 4'h0, 1'b0, 400);
		for (int k = 0; k < 4; k++)
			t_flash(2'(k), 1'b0, k + 1);
		t_flash(2'h3, 1'b1, 1);
		set(2'h0, 2'h0, 4'h0, 1'b1, 400);
		t_flash(2'h2, 1'b0, 3);
		t_pll();
		end_of_test();
	end
endmodule : tb_mcg_top

`default_nettype wire
